// file: hw/hgate_top.sv
// Host port gate decoder, input-full interrupts and host request latches
// What this block does
// R1: Hardware drives gate only while fast gate enable bit 0 is set.
// R2: Software sets gate pin direction bit to make the pin an output; this block has no such bit and always drives the pin.
// R3: On enabling fast gate, gate starts at port latch value one.
// R4: Gate decoding watches only first chip select writes.
// R5: Command D1 makes bit 1 of next data byte the gate level.
// R6: Gate rises at write strobe rise for D1 data with bit 1 set.
// R7: Gate falls at write strobe rise for D1 data with bit 1 clear.
// R8: No CPU interrupt for D1, its data, or following FF command.
// R9: Other command instead of data cancels, keeps gate, raises interrupt.
// R10: Repeated D1 while waiting restarts wait silently.
// R11: Input-full interrupt per register when full and enabled.
// R12: Request latches drive host outputs only in slave mode.
// R13: Latch a bit 3: set by read 0 then write 1; cleared by write 0 or read of output two.
// R14: Latch b bit 4: same set; cleared by write 0 or read of output one.
// R15: Latch c bit 5: same set; cleared by write 0 or read of output one.
// R16: Read strobe fall, select one, line low clears latches b and c.
// R17: Read strobe fall, select two, line low clears latch a.
// R18: Host handler reads matching output register to release its latch.
// R19: Slave mode active when host interface enable bit 1 is set.
// R20: Line high means command byte, low means data byte.
// R21: Full flag set by host write, cleared by slave read.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module hgate_top
	import hgate_pkg::*;
(
	input wire logic i_clock, // 20 MHz clock
	input wire logic i_reset, // Async reset, active high
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [15:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error, unmapped address
	input wire logic i_chip_select_one_n, // Host select one, low
	input wire logic i_chip_select_two_n, // Host select two, low
	input wire logic i_host_read_strobe_n, // Host read strobe, low
	input wire logic i_host_write_strobe_n, // Host write strobe, low
	input wire logic i_command_data_select_line, // High: command
	input wire logic [7:0] i_host_data, // Host write data
	output logic o_gate_output_pin, // Gate level
	output logic o_host_request_latch_a, // Host request a
	output logic o_host_request_latch_b, // Host request b
	output logic o_host_request_latch_c, // Host request c
	output logic o_input_full_irq_one, // CPU irq for input one
	output logic o_input_full_irq_two // CPU irq for input two
);
	import hgate_pkg::*;

	logic [7:0] host_if_ctrl_q;
	logic [7:0] sys_ctrl_q;
	logic [7:0] port_data_q;
	logic [1:0] irq_en_q;
	logic [7:0] in_data_one_q;
	logic [7:0] in_data_two_q;
	logic full_one_q;
	logic full_two_q;
	logic cmd_one_q;
	logic cmd_two_q;
	logic [7:0] seen_zero_q;
	hgate_state_e state_q;
	hgate_state_e state_d;
	logic cpu_flag_q;
	logic [31:0] rdata_q;

	logic wr_rise;
	logic rd_fall;
	hgate_edge u_wr_edge
	(
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_level(i_host_write_strobe_n),
		.o_rise(wr_rise),
		.o_fall()
	);
	hgate_edge u_rd_edge
	(
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_level(i_host_read_strobe_n),
		.o_rise(),
		.o_fall(rd_fall)
	);

	wire slave_mode = sys_ctrl_q[HGATE_HOST_IF_ENABLE_BIT]; // see R19
	wire fast_gate = host_if_ctrl_q[HGATE_FAST_GATE_ENABLE_BIT];
	wire cs1 = ~i_chip_select_one_n & i_chip_select_two_n;
	wire cs2 = ~i_chip_select_two_n & i_chip_select_one_n;
	wire host_wr_one = slave_mode & wr_rise & cs1;
	wire host_wr_two = slave_mode & wr_rise & cs2;
	wire is_cmd = i_command_data_select_line; // see R20
	wire rd_out_one = slave_mode & rd_fall & cs1 & ~i_command_data_select_line; // see R16
	wire rd_out_two = slave_mode & rd_fall & cs2 & ~i_command_data_select_line; // see R17

	// APB access decode; zero wait states
	wire apb_acc = i_psel & i_penable;
	wire apb_wr = apb_acc & i_pwrite;
	wire apb_rd = apb_acc & ~i_pwrite;
	wire hit_hic = i_paddr == HGATE_HOST_IF_CTRL_OFS;
	wire hit_sys = i_paddr == HGATE_SYS_CTRL_OFS;
	wire hit_port = i_paddr == HGATE_PORT_DATA_OFS;
	wire hit_ien = i_paddr == HGATE_IRQ_EN_OFS;
	wire hit_sts = i_paddr == HGATE_IN_STATUS_OFS;
	wire hit_id1 = i_paddr == HGATE_IN_DATA_ONE_OFS;
	wire hit_id2 = i_paddr == HGATE_IN_DATA_TWO_OFS;
	wire mapped = hit_hic | hit_sys | hit_port | hit_ien | hit_sts | hit_id1 | hit_id2;
	wire [7:0] wbyte = i_pwdata[7:0];
	wire slave_rd_one = apb_rd & hit_id1;
	wire slave_rd_two = apb_rd & hit_id2;
	wire port_wr = apb_wr & hit_port;

	// Gate command decoder, only for select one writes
	wire gate_cmd = host_wr_one & is_cmd & (i_host_data == HGATE_CMD_GATE); // see R4, R5
	wire nop_cmd = host_wr_one & is_cmd & (i_host_data == HGATE_CMD_NOP);
	wire gate_data = host_wr_one & ~is_cmd & (state_q == HGATE_WAIT_DATA);
	logic suppress_irq;
	always_comb
	begin
		state_d = state_q;
		suppress_irq = 1'b0;
		if (!fast_gate)
			state_d = HGATE_IDLE;
		else if (host_wr_one)
		begin
			case (state_q)
				HGATE_IDLE:
				begin
					if (gate_cmd)
					begin
						state_d = HGATE_WAIT_DATA;
						suppress_irq = 1'b1; // see R8
					end
				end
				HGATE_WAIT_DATA:
				begin
					if (gate_cmd)
					begin
						state_d = HGATE_WAIT_DATA;
						suppress_irq = 1'b1; // see R10
					end
					else if (!is_cmd)
					begin
						state_d = HGATE_AFTER_DATA;
						suppress_irq = 1'b1; // see R8
					end
					else
						state_d = HGATE_IDLE; // see R9
				end
				HGATE_AFTER_DATA:
				begin
					if (gate_cmd)
					begin
						state_d = HGATE_WAIT_DATA;
						suppress_irq = 1'b1;
					end
					else if (nop_cmd)
					begin
						state_d = HGATE_IDLE;
						suppress_irq = 1'b1; // see R8
					end
					else
						state_d = HGATE_IDLE; // see R8
				end
				default: state_d = HGATE_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			state_q <= HGATE_IDLE;
		else
			state_q <= state_d;
	end

	// Gate level lives in the port data latch bit; reset value is one
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			port_data_q <= HGATE_PORT_DATA_RESET; // see R3
		else
		begin
			if (fast_gate && gate_data)
				port_data_q[HGATE_GATE_BIT] <= i_host_data[HGATE_GATE_DATA_BIT]; // see R6, R7
			else if (port_wr && !fast_gate)
				port_data_q[HGATE_GATE_BIT] <= wbyte[HGATE_GATE_BIT]; // see R1
			if (port_wr)
			begin
				port_data_q[2:0] <= wbyte[2:0];
				port_data_q[6] <= wbyte[6];
			end
			// Hardware clear beats a same-cycle write of one, as the host read removes the cause
			if (port_wr && !wbyte[HGATE_LATCH_A_BIT])
				port_data_q[HGATE_LATCH_A_BIT] <= 1'b0; // see R13
			else if (port_wr && seen_zero_q[HGATE_LATCH_A_BIT] && !rd_out_two)
				port_data_q[HGATE_LATCH_A_BIT] <= 1'b1; // see R13
			else if (rd_out_two)
				port_data_q[HGATE_LATCH_A_BIT] <= 1'b0; // see R17
			if (port_wr && !wbyte[HGATE_LATCH_B_BIT])
				port_data_q[HGATE_LATCH_B_BIT] <= 1'b0; // see R14
			else if (port_wr && seen_zero_q[HGATE_LATCH_B_BIT] && !rd_out_one)
				port_data_q[HGATE_LATCH_B_BIT] <= 1'b1; // see R14
			else if (rd_out_one)
				port_data_q[HGATE_LATCH_B_BIT] <= 1'b0; // see R16
			if (port_wr && !wbyte[HGATE_LATCH_C_BIT])
				port_data_q[HGATE_LATCH_C_BIT] <= 1'b0; // see R15
			else if (port_wr && seen_zero_q[HGATE_LATCH_C_BIT] && !rd_out_one)
				port_data_q[HGATE_LATCH_C_BIT] <= 1'b1; // see R15
			else if (rd_out_one)
				port_data_q[HGATE_LATCH_C_BIT] <= 1'b0; // see R16
		end
	end

	// Remembers that software saw a latch at zero, arming the set
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			seen_zero_q <= 8'h00;
		else if (apb_rd && hit_port)
			seen_zero_q <= ~port_data_q;
		else if (port_wr)
			seen_zero_q <= 8'h00;
	end

	// Input registers and full flags; host write sets, slave read clears, set wins
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			in_data_one_q <= 8'h00;
			in_data_two_q <= 8'h00;
			cmd_one_q <= 1'b0;
			cmd_two_q <= 1'b0;
			full_one_q <= 1'b0;
			full_two_q <= 1'b0;
			cpu_flag_q <= 1'b0;
		end
		else
		begin
			if (host_wr_one)
			begin
				in_data_one_q <= i_host_data;
				cmd_one_q <= is_cmd; // see R20
			end
			if (host_wr_two)
			begin
				in_data_two_q <= i_host_data;
				cmd_two_q <= is_cmd;
			end
			if (host_wr_one && !(fast_gate && suppress_irq))
				cpu_flag_q <= 1'b1; // see R8, R9
			else if (slave_rd_one)
				cpu_flag_q <= 1'b0;
			if (host_wr_one)
				full_one_q <= 1'b1; // see R21
			else if (slave_rd_one)
				full_one_q <= 1'b0; // see R21
			if (host_wr_two)
				full_two_q <= 1'b1; // see R21
			else if (slave_rd_two)
				full_two_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			host_if_ctrl_q <= HGATE_HOST_IF_CTRL_RESET;
			sys_ctrl_q <= HGATE_SYS_CTRL_RESET;
			irq_en_q <= 2'b00;
		end
		else if (apb_wr)
		begin
			if (hit_hic)
				host_if_ctrl_q <= wbyte;
			else if (hit_sys)
				sys_ctrl_q <= wbyte;
			else if (hit_ien)
				irq_en_q <= wbyte[1:0];
		end
	end

	wire [7:0] status_byte = {3'b000, cmd_two_q, cmd_one_q, cpu_flag_q, full_two_q, full_one_q};
	wire [7:0] rd_byte = hit_hic ? host_if_ctrl_q :
		hit_sys ? sys_ctrl_q :
		hit_port ? port_data_q :
		hit_ien ? {6'b000000, irq_en_q} :
		hit_sts ? status_byte :
		hit_id1 ? in_data_one_q :
		hit_id2 ? in_data_two_q : 8'h00;
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			rdata_q <= 32'h00000000;
		else if (i_psel && !i_penable && !i_pwrite)
			rdata_q <= {24'h000000, rd_byte};
	end
	assign o_prdata = rdata_q;
	assign o_pready = 1'b1;
	assign o_pslverr = apb_acc & ~mapped;

	// Gate pin direction is the far side's job; the pin level is the latch bit
	assign o_gate_output_pin = port_data_q[HGATE_GATE_BIT]; // see R1, R2
	assign o_host_request_latch_a = slave_mode & port_data_q[HGATE_LATCH_A_BIT]; // see R12
	assign o_host_request_latch_b = slave_mode & port_data_q[HGATE_LATCH_B_BIT]; // see R12
	assign o_host_request_latch_c = slave_mode & port_data_q[HGATE_LATCH_C_BIT]; // see R12
	// Fast gate traffic that is swallowed does not raise the one irq
	assign o_input_full_irq_one = cpu_flag_q & irq_en_q[0]; // see R11
	assign o_input_full_irq_two = full_two_q & irq_en_q[1]; // see R11

	sequence s_gate_data;
		fast_gate && gate_data;
	endsequence
	a_gate_follows_data: assert property (@(posedge i_clock) disable iff (i_reset) // see R6
		s_gate_data |=> o_gate_output_pin == $past(i_host_data[1]))
		else $error("gate level not taken from data");
	a_gate_held_cancel: assert property (@(posedge i_clock) disable iff (i_reset) // see R9
		(fast_gate && host_wr_one && is_cmd && !gate_cmd && state_q == HGATE_WAIT_DATA)
		|=> $stable(o_gate_output_pin) && cpu_flag_q)
		else $error("cancel changed gate or missed irq");
	a_d1_no_irq: assert property (@(posedge i_clock) disable iff (i_reset) // see R8
		(fast_gate && gate_cmd && !cpu_flag_q && !slave_rd_one) |=> !cpu_flag_q)
		else $error("irq raised for gate command");
	a_retrigger_wait: assert property (@(posedge i_clock) disable iff (i_reset) // see R10
		(fast_gate && gate_cmd) |=> state_q == HGATE_WAIT_DATA)
		else $error("gate command did not arm wait");
	a_cs_two_ignored: assert property (@(posedge i_clock) disable iff (i_reset) // see R4
		(host_wr_two && !host_wr_one && !port_wr) |=> $stable(o_gate_output_pin))
		else $error("select two moved gate");
	a_latch_b_clear: assert property (@(posedge i_clock) disable iff (i_reset) // see R16
		rd_out_one |=> !port_data_q[HGATE_LATCH_B_BIT] && !port_data_q[HGATE_LATCH_C_BIT])
		else $error("latch b or c not cleared");
	a_latch_a_clear: assert property (@(posedge i_clock) disable iff (i_reset) // see R17
		rd_out_two |=> !port_data_q[HGATE_LATCH_A_BIT])
		else $error("latch a not cleared");
	a_irq_two_full: assert property (@(posedge i_clock) disable iff (i_reset) // see R11
		(host_wr_two && irq_en_q[1] && !apb_wr) |=> o_input_full_irq_two)
		else $error("irq two missing");
	a_latch_out_gated: assert property (@(posedge i_clock) disable iff (i_reset) // see R12
		!slave_mode |-> !o_host_request_latch_a && !o_host_request_latch_b && !o_host_request_latch_c)
		else $error("latch output outside slave mode");
	a_soft_gate: assert property (@(posedge i_clock) disable iff (i_reset) // see R1
		(!fast_gate && !port_wr) |=> $stable(o_gate_output_pin))
		else $error("gate moved without fast gate");
	a_full_one_set: assert property (@(posedge i_clock) disable iff (i_reset) // see R21
		host_wr_one |=> full_one_q)
		else $error("host write did not fill input one");
endmodule : hgate_top

// file: hw/hgate_pkg.sv
// Package: register map, field positions and constants of the host gate block
package hgate_pkg;
	localparam logic [15:0] HGATE_HOST_IF_CTRL_OFS = 16'hfff0;
	localparam logic [15:0] HGATE_SYS_CTRL_OFS = 16'hffc4;
	localparam logic [15:0] HGATE_PORT_DATA_OFS = 16'hff00;
	localparam logic [15:0] HGATE_IRQ_EN_OFS = 16'hff04;
	localparam logic [15:0] HGATE_IN_STATUS_OFS = 16'hff08;
	localparam logic [15:0] HGATE_IN_DATA_ONE_OFS = 16'hff0c;
	localparam logic [15:0] HGATE_IN_DATA_TWO_OFS = 16'hff10;
	localparam int HGATE_FAST_GATE_ENABLE_BIT = 0;
	localparam int HGATE_HOST_IF_ENABLE_BIT = 1;
	localparam int HGATE_LATCH_A_BIT = 3;
	localparam int HGATE_LATCH_B_BIT = 4;
	localparam int HGATE_LATCH_C_BIT = 5;
	localparam int HGATE_GATE_BIT = 7;
	localparam int HGATE_GATE_DATA_BIT = 1;
	localparam logic [7:0] HGATE_CMD_GATE = 8'hd1;
	localparam logic [7:0] HGATE_CMD_NOP = 8'hff;
	localparam logic [7:0] HGATE_SYS_CTRL_RESET = 8'h09;
	localparam logic [7:0] HGATE_PORT_DATA_RESET = 8'h80;
	localparam logic [7:0] HGATE_HOST_IF_CTRL_RESET = 8'h00;
	typedef enum logic [1:0] {HGATE_IDLE, HGATE_WAIT_DATA, HGATE_AFTER_DATA} hgate_state_e;
endpackage : hgate_pkg

// file: hw/hgate_edge.sv
// Edge detector for the host strobes
`timescale 1ns/1ps
module hgate_edge
(
	input wire logic i_clock, // 20 MHz clock
	input wire logic i_reset, // Async reset, high
	input wire logic i_level, // Sampled strobe level
	output logic o_rise, // Rising edge pulse
	output logic o_fall // Falling edge pulse
);
	logic prev_q;
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			prev_q <= 1'b1;
		else
			prev_q <= i_level;
	end
	assign o_rise = i_level & ~prev_q;
	assign o_fall = ~i_level & prev_q;
endmodule : hgate_edge

// file: bench/hgate_host_model.sv
// Host processor model for the parallel host port
`timescale 1ns/1ps
module hgate_host_model
(
	input wire logic i_clock, // Bench clock
	output logic o_cs_one_n, // Select one, low
	output logic o_cs_two_n, // Select two, low
	output logic o_rd_n, // Read strobe, low
	output logic o_wr_n, // Write strobe, low
	output logic o_line, // High: command
	output logic [7:0] o_data // Write data
);
	initial
	begin
		o_cs_one_n = 1'b1;
		o_cs_two_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_line = 1'b0;
		o_data = 8'h00;
	end
	// Select and line settle a cycle before the strobe and outlast it
	task automatic access(input logic sel, input logic wr, input logic ln, input logic [7:0] v);
		@(posedge i_clock);
		o_cs_one_n <= sel;
		o_cs_two_n <= !sel;
		o_line <= ln;
		o_data <= v;
		@(posedge i_clock);
		if (wr)
			o_wr_n <= 1'b0;
		else
			o_rd_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		o_wr_n <= 1'b1;
		o_rd_n <= 1'b1;
		repeat (2) @(posedge i_clock);
		o_cs_one_n <= 1'b1;
		o_cs_two_n <= 1'b1;
		// A released bus must not keep showing the byte
		o_data <= ~v;
	endtask : access
endmodule : hgate_host_model

// file: bench/tb_hgate_top.sv
// Self-checking bench of the host gate block
`timescale 1ns/1ps
module tb_hgate_top;
	import hgate_pkg::*;
	logic i_clock, i_reset, psel, pen, pwr, pready, pslverr, err;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cs1, cs2, rdn, wrn, line, gate, la, lb, lc, irq1, irq2;
	logic [7:0] hd, d, c, x;
	logic [31:0] lfsr = 32'h7646;
	int num_errors = 0;
	int n_tests = 0;
	hgate_top u_hgate_top (.i_clock(i_clock), .i_reset(i_reset), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_chip_select_one_n(cs1), .i_chip_select_two_n(cs2), .i_host_read_strobe_n(rdn),
		.i_host_write_strobe_n(wrn), .i_command_data_select_line(line), .i_host_data(hd),
		.o_gate_output_pin(gate), .o_host_request_latch_a(la), .o_host_request_latch_b(lb),
		.o_host_request_latch_c(lc), .o_input_full_irq_one(irq1), .o_input_full_irq_two(irq2));
	hgate_host_model u_hgate_host_model (.i_clock(i_clock), .o_cs_one_n(cs1),
		.o_cs_two_n(cs2), .o_rd_n(rdn), .o_wr_n(wrn), .o_line(line), .o_data(hd));
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand
	// After gate data, only commands outside the gate pair reach the CPU
	function automatic logic raises(input logic [7:0] cmd);
		return cmd != HGATE_CMD_GATE && cmd != HGATE_CMD_NOP;
	endfunction : raises
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic results();
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
		@(posedge i_clock);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clock);
		pen <= 1'b1;
		// No own limit: only the watchdog ends a wait for the answer
		do
			@(posedge i_clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// Flags written at the access edge are settled by the falling edge
		@(negedge i_clock);
	endtask : apb
	task automatic hw(input logic sel, input logic ln, input logic [7:0] v);
		u_hgate_host_model.access(sel, 1'b1, ln, v);
		repeat (2) @(posedge i_clock);
	endtask : hw
	task automatic hr(input logic sel);
		u_hgate_host_model.access(sel, 1'b0, 1'b0, 8'h00);
		repeat (2) @(posedge i_clock);
	endtask : hr
	// Port data read showing zero, then the write of ones
	task automatic arm();
		apb(1'b0, HGATE_PORT_DATA_OFS, 32'h0);
		apb(1'b1, HGATE_PORT_DATA_OFS, 32'h38);
	endtask : arm
	initial
	begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	initial
	begin
		repeat (5000) @(posedge i_clock);
		num_errors++;
		results();
	end
	initial
	begin
		i_reset = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 16'h0;
		pwdata = 32'h0;
		repeat (10) @(posedge i_clock);
		i_reset <= 1'b0;
		check(gate, 1);
		check({la, lb, lc, irq1, irq2}, 0);
		apb(1'b0, HGATE_SYS_CTRL_OFS, 32'h0);
		check(rd, HGATE_SYS_CTRL_RESET);
		apb(1'b0, HGATE_PORT_DATA_OFS, 32'h0);
		check(rd, HGATE_PORT_DATA_RESET);
		apb(1'b0, HGATE_HOST_IF_CTRL_OFS, 32'h0);
		check(rd, HGATE_HOST_IF_CTRL_RESET);
		apb(1'b0, 16'hff14, 32'h0);
		check(err, 1);
		check(rd, 0);
		apb(1'b1, HGATE_SYS_CTRL_OFS, 32'h0b);
		apb(1'b1, HGATE_IRQ_EN_OFS, 32'h3);
		apb(1'b1, HGATE_HOST_IF_CTRL_OFS, 32'h1);
		check(gate, 1);
		for (int i = 0; i < 8; i++)
		begin
			lfsr = next_rand(lfsr);
			d = lfsr[7:0];
			c = lfsr[15:8];
			d[1] = i[0] ^ i[2];
			if (!raises(c))
				c = 8'h20;
			x = i[1] ? HGATE_CMD_NOP : c;
			hw(1'b0, 1'b1, HGATE_CMD_GATE);
			if (i[0])
				hw(1'b0, 1'b1, HGATE_CMD_GATE);
			check(irq1, 0);
			hw(1'b0, 1'b0, d);
			check({gate, irq1}, {d[1], 1'b0});
			hw(1'b0, 1'b1, x);
			check({gate, irq1}, {d[1], raises(x)});
			if (raises(x))
			begin
				apb(1'b0, HGATE_IN_DATA_ONE_OFS, 32'h0);
				check(rd, {24'h0, x});
				check(irq1, 0);
			end
		end
		hw(1'b0, 1'b1, HGATE_CMD_GATE);
		hw(1'b0, 1'b1, c);
		check({gate, irq1}, {d[1], 1'b1});
		apb(1'b0, HGATE_IN_STATUS_OFS, 32'h0);
		check(rd & 32'h0d, 32'h0d);
		apb(1'b1, HGATE_IRQ_EN_OFS, 32'h2);
		apb(1'b0, HGATE_IN_DATA_ONE_OFS, 32'h0);
		hw(1'b0, 1'b1, c);
		check(irq1, 0);
		apb(1'b1, HGATE_IRQ_EN_OFS, 32'h3);
		check(irq1, 1);
		apb(1'b0, HGATE_IN_DATA_ONE_OFS, 32'h0);
		hw(1'b1, 1'b1, HGATE_CMD_GATE);
		hw(1'b1, 1'b0, {6'h0, ~d[1], 1'b0});
		check({gate, irq2}, {d[1], 1'b1});
		apb(1'b0, HGATE_IN_DATA_TWO_OFS, 32'h0);
		check(rd, {24'h0, 6'h0, ~d[1], 1'b0});
		check(irq2, 0);
		apb(1'b1, HGATE_HOST_IF_CTRL_OFS, 32'h0);
		hw(1'b0, 1'b1, HGATE_CMD_GATE);
		check(irq1, 1);
		hw(1'b0, 1'b0, {6'h0, ~d[1], 1'b0});
		check(gate, d[1]);
		apb(1'b0, HGATE_IN_DATA_ONE_OFS, 32'h0);
		apb(1'b1, HGATE_PORT_DATA_OFS, 32'h00);
		check(gate, 0);
		arm();
		check({la, lb, lc}, 3'b111);
		hr(1'b0);
		check({la, lb, lc}, 3'b100);
		hr(1'b1);
		check({la, lb, lc}, 3'b000);
		apb(1'b1, HGATE_PORT_DATA_OFS, 32'h38);
		check({la, lb, lc}, 3'b000);
		arm();
		apb(1'b1, HGATE_PORT_DATA_OFS, 32'h00);
		check({la, lb, lc}, 3'b000);
		arm();
		apb(1'b1, HGATE_SYS_CTRL_OFS, 32'h09);
		check({la, lb, lc}, 3'b000);
		apb(1'b1, HGATE_SYS_CTRL_OFS, 32'h0b);
		check({la, lb, lc}, 3'b111);
		results();
	end
endmodule : tb_hgate_top
